/* rtl/scpu_exec.sv */
// Purpose: execution of branch-if-nonzero, port moves and multiply
// Assumes: program memory answers combinationally on prog_addr
// Notes: other opcodes are treated as no-operation; only those with high nibble fh are flagged
//
// Contract
// - nonzero index adds operand, else pc plus one
// - next fetch uses updated counter only
// - read port copies port to accumulator
// - write port copies accumulator to port
// - any of sixteen ports; writing port fh with bit15 set also starts a module access
// - multiply opcode f3h, register field 3h
// - sixteen-cycle product plus starting accumulator, high to accumulator, low multiplier
// - multiplicand kept, multiplier gets low word
// - register 0h is the fetch pointer
// - register 1h is the accumulator
// - registers 3h, 4h multiply operands, else general
// - register 5h is the branch index
// - registers 2h, 6h-fh plain storage
// - control port bit15 starts, bit14 selects read
// - address port low byte, data port read overwrite
`timescale 1ns/10ps
`default_nettype none
module scpu_exec
    import scpu_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // program memory
    output logic [15:0] prog_addr,
    input wire logic [7:0] prog_data,
    // module port side
    output scpu_pkg::scpu_mod_req_t mod_req,
    input wire scpu_pkg::scpu_mod_rsp_t mod_rsp,
    // status
    output logic busy,
    output logic illegal_op,
    output logic [15:0] program_counter,
    output logic [15:0] accumulator_reg
);
    import scpu_pkg::*;

    scpu_state_s_t s_q;
    scpu_state_s_t s_d;
    logic [3:0] op_hi;
    logic [3:0] op_x;
    logic [16:0] mult_sum;

    function automatic logic is_multiply(input logic [7:0] op);
        is_multiply = (op == OPC_MULTIPLY);
    endfunction

    assign op_hi = prog_data[7:4];
    assign op_x = prog_data[3:0];
    // one spare bit so the add carry reaches the product high word
    assign mult_sum = {1'b0, s_q.prod[31:16]} + {1'b0, s_q.regs[REG_MULTIPLICAND]};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        case (s_q.state)
            SCPU_FETCH: begin
                if (is_multiply(prog_data)) begin
                    // shift-add keeps area small; 16 cycles matches timing
                    s_d.state = SCPU_MULT;
                    s_d.mcount = '0;
                    s_d.prod = {s_q.regs[REG_ACCUMULATOR], s_q.regs[REG_MULTIPLIER]};
                end else begin
                    s_d.pc = s_q.pc + 16'h0001;
                    case (op_hi)
                        OPC_BRANCH_IF_NONZERO: begin
                            if (s_q.regs[REG_BRANCH_INDEX] != INDEX_ZERO) begin
                                s_d.pc = s_q.pc + s_q.regs[op_x];
                            end
                        end
                        OPC_READ_PORT: begin
                            s_d.regs[REG_ACCUMULATOR] = s_q.ports[op_x];
                        end
                        OPC_WRITE_PORT: begin
                            s_d.ports[op_x] = s_q.regs[REG_ACCUMULATOR];
                            if (op_x == PORT_MODULE_CONTROL
                                && s_q.regs[REG_ACCUMULATOR][CTRL_START_BIT]) begin
                                s_d.state = SCPU_MODULE;
                            end
                        end
                        default: begin
                            s_d.illegal = s_q.illegal | (op_hi == 4'hf);
                        end
                    endcase
                end
            end
            SCPU_MULT: begin
                // prod holds partial product high and remaining multiplier low
                if (s_q.prod[0]) begin
                    s_d.prod = {mult_sum, s_q.prod[15:1]};
                end else begin
                    s_d.prod = {1'b0, s_q.prod[31:1]};
                end
                s_d.mcount = s_q.mcount + 5'h01;
                if (s_q.mcount == MULT_CYCLES - 5'h01) begin
                    s_d.state = SCPU_FETCH;
                    s_d.regs[REG_ACCUMULATOR] = s_d.prod[31:16];
                    s_d.regs[REG_MULTIPLIER] = s_d.prod[15:0];
                    s_d.pc = s_q.pc + 16'h0001;
                end
            end
            SCPU_MODULE: begin
                if (mod_rsp.done) begin
                    s_d.state = SCPU_FETCH;
                    s_d.ports[PORT_MODULE_CONTROL][CTRL_START_BIT] = 1'b0;
                    if (s_q.ports[PORT_MODULE_CONTROL][CTRL_READ_BIT]) begin
                        s_d.ports[PORT_MODULE_DATA] = mod_rsp.rdata;
                    end
                end
            end
            default: begin
                s_d.state = SCPU_FETCH;
            end
        endcase
        // pointer register mirrors the fetch address
        s_d.regs[REG_FETCH_POINTER] = s_d.pc;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prog_addr = s_q.pc;
    assign busy = (s_q.state != SCPU_FETCH);
    assign illegal_op = s_q.illegal;
    assign program_counter = s_q.pc;
    assign accumulator_reg = s_q.regs[REG_ACCUMULATOR];
    assign mod_req.start = (s_q.state == SCPU_MODULE);
    assign mod_req.read = s_q.ports[PORT_MODULE_CONTROL][CTRL_READ_BIT];
    assign mod_req.addr = s_q.ports[PORT_MODULE_ADDRESS][MOD_ADDR_W-1:0];
    assign mod_req.wdata = s_q.ports[PORT_MODULE_DATA];
endmodule
`default_nettype wire

/* rtl/scpu_pkg.sv */
// Purpose: shared constants and types for the sensor cpu execution block
// Assumes: 16-bit datapath, 16 registers, 16 ports, byte-wide opcodes
// Notes: no documented reset values; zero is used throughout
package scpu_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned PC_W = 16;
    localparam logic [3:0] REG_FETCH_POINTER = 4'h0;
    localparam logic [3:0] REG_ACCUMULATOR = 4'h1;
    localparam logic [3:0] REG_GENERAL_TWO = 4'h2;
    localparam logic [3:0] REG_MULTIPLICAND = 4'h3;
    localparam logic [3:0] REG_MULTIPLIER = 4'h4;
    localparam logic [3:0] REG_BRANCH_INDEX = 4'h5;
    localparam logic [3:0] REG_GENERAL_UPPER = 4'h6;
    localparam logic [3:0] PORT_MODULE_DATA = 4'hd;
    localparam logic [3:0] PORT_MODULE_ADDRESS = 4'he;
    localparam logic [3:0] PORT_MODULE_CONTROL = 4'hf;
    localparam int unsigned CTRL_START_BIT = 15;
    localparam int unsigned CTRL_READ_BIT = 14;
    localparam int unsigned MOD_ADDR_W = 8;
    localparam logic [3:0] OPC_BRANCH_IF_NONZERO = 4'hc;
    localparam logic [3:0] OPC_READ_PORT = 4'hd;
    localparam logic [3:0] OPC_WRITE_PORT = 4'he;
    localparam logic [7:0] OPC_MULTIPLY = 8'hf3;
    localparam logic [15:0] INDEX_ZERO = 16'h0000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [4:0] MULT_CYCLES = 5'h10;

    typedef enum logic [1:0] {
        SCPU_FETCH = 2'b00,
        SCPU_MULT = 2'b01,
        SCPU_MODULE = 2'b10
    } scpu_state_t;

    typedef struct packed {
        logic start;
        logic read;
        logic [7:0] addr;
        logic [15:0] wdata;
    } scpu_mod_req_t;

    typedef struct packed {
        logic done;
        logic [15:0] rdata;
    } scpu_mod_rsp_t;

    typedef struct packed {
        scpu_state_t state;
        logic [15:0] pc;
        logic [15:0][15:0] regs;
        logic [15:0][15:0] ports;
        logic [4:0] mcount;
        logic [31:0] prod;
        logic illegal;
    } scpu_state_s_t;
endpackage

/* verif/scpu_exec_asserts.sv */
// Purpose: port checks for scpu_exec
// Assumes: fetch state while busy low
// Notes: none
`timescale 1ns/10ps
`default_nettype none
module scpu_chk
    import scpu_pkg::*;
(
    // watched ports
    input wire logic mclk,
    input wire logic rst,
    input wire logic [15:0] prog_addr,
    input wire logic [7:0] prog_data,
    input wire scpu_pkg::scpu_mod_req_t mod_req,
    input wire scpu_pkg::scpu_mod_rsp_t mod_rsp,
    input wire logic busy,
    input wire logic illegal_op,
    input wire logic [15:0] program_counter,
    input wire logic [15:0] accumulator_reg
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic f = !busy;
    wire logic [15:0] pc = program_counter;
    wire logic [7:0] op = prog_data;
    property p_mv;
        f && (op[7:4] == 4'hd || op[7:4] == 4'he) |=> pc == $past(pc) + 16'h1;
    endproperty
    a_mv: assert property (p_mv) else $error("port move step");
    property p_bn; f && op[7:4] == 4'hc |=> f; endproperty
    a_bn: assert property (p_bn) else $error("branch not single");
    property p_wr; f && op[7:4] == 4'he |=> $stable(accumulator_reg); endproperty
    a_wr: assert property (p_wr) else $error("write changed acc");
    property p_ml; f && op == 8'hf3 |=> busy[*8] ##1 busy[*8] ##1 f; endproperty
    a_ml: assert property (p_ml) else $error("multiply length");
    property p_mp; f && op == 8'hf3 |=> ##16 pc == $past(pc, 17) + 16'h1; endproperty
    a_mp: assert property (p_mp) else $error("multiply pc");
    property p_st; busy ##1 busy |-> $stable(pc); endproperty
    a_st: assert property (p_st) else $error("fetch not stalled");
    property p_fa; prog_addr == pc; endproperty
    a_fa: assert property (p_fa) else $error("fetch address");
    property p_il; f && op[7:4] == 4'hf && op[3:0] != 4'h3 |=> illegal_op; endproperty
    a_il: assert property (p_il) else $error("illegal not flagged");
    property p_md; mod_req.start && mod_rsp.done |=> !mod_req.start; endproperty
    a_md: assert property (p_md) else $error("start not cleared");
endmodule
bind scpu_exec scpu_chk u_chk (.mclk, .rst, .prog_addr, .prog_data, .mod_req, .mod_rsp,
    .busy, .illegal_op, .program_counter, .accumulator_reg);
`default_nettype wire

/* verif/scpu_flash_model.sv */
// Purpose: program memory and module responder
// Assumes: combinational fetch
// Notes: rdata moves outside done
`timescale 1ns/10ps
`default_nettype none
module scpu_flash_model
    import scpu_pkg::*;
(
    // clock and links
    input wire logic mclk,
    input wire logic [15:0] prog_addr,
    output logic [7:0] prog_data,
    input wire scpu_pkg::scpu_mod_req_t mod_req,
    output scpu_pkg::scpu_mod_rsp_t mod_rsp
);
    logic [7:0] mem [0:255];
    logic [1:0] wt;
    assign prog_data = mem[prog_addr[7:0]];
    always @(posedge mclk) begin
        wt <= (mod_req.start && !mod_rsp.done) ? wt + 2'h1 : 2'h0;
        mod_rsp.done <= mod_req.start && wt == 2'h2;
        mod_rsp.rdata <= (mod_req.start && wt == 2'h2) ? 16'h5a5a : ~prog_addr;
    end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Purpose: directed program run
// Assumes: accumulator stays zero
// Notes: nothing here loads a nonzero accumulator
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((ex) !== (got)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench;
    import scpu_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] prog_addr, program_counter, accumulator_reg;
    logic [7:0] prog_data;
    scpu_mod_req_t mod_req;
    scpu_mod_rsp_t mod_rsp;
    logic busy, illegal_op;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc;
    int steps [5] = '{1, 1, 1, 17, 1};
    always #4 mclk = ~mclk;
    scpu_exec DUT (.mclk, .rst, .prog_addr, .prog_data, .mod_req, .mod_rsp, .busy,
        .illegal_op, .program_counter, .accumulator_reg);
    scpu_flash_model FLASH (.mclk, .prog_addr, .prog_data, .mod_req, .mod_rsp);
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic load(input int a, input logic [7:0] v);
        FLASH.mem[a] = v;
    endtask
    task automatic run_to(input logic [15:0] v, output int c);
        c = 0;
        while (program_counter !== v && c < 100) begin
            @(negedge mclk);
            c++;
        end
        if (c == 100) begin
            n_errors++;
            stop_test();
        end
    endtask
    initial begin
        for (int i = 0; i < 256; i++) begin
            load(i, 8'h00);
        end
        load(0, 8'hd5);
        load(1, 8'hc2);
        load(2, 8'he4);
        load(3, OPC_MULTIPLY);
        load(4, 8'hf5);
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            `CHK("illegal", 1'b0, illegal_op)
            run_to(16'(i + 1), cyc);
            `CHK("cycles", steps[i], cyc)
        end
        `CHK("illegal", 1'b1, illegal_op)
        `CHK("acc", 16'h0000, accumulator_reg)
        `CHK("fetch", 16'h0005, prog_addr)
        `CHK("busy", 1'b0, busy)
        `CHK("start", 1'b0, mod_req.start)
        run_to(16'h0009, cyc);
        `CHK("nops", 4, cyc)
        `CHK("sticky", 1'b1, illegal_op)
        stop_test();
    end
endmodule
`default_nettype wire
